// *** psmp_parser.sv ***
// module: receive-side segment chain parser of publish-subscribe messages
// Function
// - truncated segment header invalidates the rest of the message.
// - segment length locates next segment; bad length discards message remainder.
// - segment of undefined kind is skipped; parsing resumes at next segment.
// - vendor-range segment from unrecognised vendor is skipped.
// - flag bits other than byte order are ignored, never rejected.
// - next segment always found by length field, never by content size.
// - known segment failing checks invalidates and stops the message.
// - only header and four info segments alter receiver context.
// - entity segments go to endpoints with the context holding then.
// - change sequence numbers are 64-bit two's-complement signed values.
// - lowest valid sequence number is 1; below is invalid.
// - sequence set valid only with minimum at least 1, span at most 256.
// - set members lie between base and base plus 255, as bitmap.
// - fragment indices are 32-bit unsigned, numbered from 1.
// - fragment set valid only with minimum at least 1, span at most 256.
// - protocol revision decoded as separate major and minor numbers.
// - first flag bit selects big-endian when clear, little-endian when set.
// - length zero means last segment running to end of message.
// - receiver context returns to initial values at every message start.
// - header rejected when major revision exceeds the supported one.
`timescale 1ns/100ps
module psmp_parser
  import psmp_pkg::*;
#(
  parameter logic [7:0]  SUPP_MAJOR   = 8'h02,
  parameter logic [7:0]  SUPP_MINOR   = 8'h04,
  // arbitrary value of the one vendor whose private segments are understood
  parameter logic [15:0] KNOWN_VENDOR = 16'h5a5a
)
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       ce,
  // message byte stream
  input  wire logic       in_valid,
  input  wire psmp_byte_s in_byte,
  output logic            in_ready,
  // entity segment stream to endpoints
  output psmp_ent_s       ent,
  output psmp_ctx_s       ctx,
  // message events
  output logic            msg_invalid,
  output logic            msg_done
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (SUPP_MAJOR == 8'h00) begin : g_bad_major
    $error("supported major revision must be non-zero");
  end
  if (KNOWN_VENDOR == VENDOR_CODE_UNSET) begin : g_bad_vendor
    $error("known vendor must differ from the unset code");
  end

  // ---------------------------------------------------------------
  // decoding helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] word_shift(input logic [31:0] acc, input logic [7:0] b, input logic le);
    word_shift = le ? {b, acc[31:8]} : {acc[23:0], b};
  endfunction

  function automatic psmp_class_e kind_class(input logic [7:0] k, input logic vendor_known);
    case (k)
      K_DATA, K_DATA_FRAGMENT, K_HEARTBEAT, K_SEGMENT_A,
      K_GAP, K_HB_FRAGMENT, K_NACK_FRAGMENT: kind_class = C_ENTITY;
      K_SRC_INFO, K_REPLY_INFO, K_DST_INFO, K_TS_INFO: kind_class = C_CTX;
      default: begin
        if (k >= VENDOR_KIND_MIN && vendor_known) kind_class = C_ENTITY;
        else kind_class = C_SKIP;
      end
    endcase
  endfunction

  function automatic logic [15:0] min_len(input logic [7:0] k);
    case (k)
      K_TS_INFO:       min_len = MIN_TS_INFO;
      K_SRC_INFO:      min_len = MIN_SRC_INFO;
      K_DST_INFO:      min_len = MIN_DST_INFO;
      K_SEGMENT_A:     min_len = MIN_SEGMENT_A;
      K_GAP:           min_len = MIN_GAP;
      K_NACK_FRAGMENT: min_len = MIN_NACK_FRAG;
      default:         min_len = MIN_NONE;
    endcase
  endfunction

  function automatic logic [15:0] set_off(input logic [7:0] k);
    case (k)
      K_SEGMENT_A:     set_off = SET_OFF_SEG_A;
      K_GAP:           set_off = SET_OFF_GAP;
      default:         set_off = SET_OFF_NACKF;
    endcase
  endfunction

  function automatic logic has_set(input logic [7:0] k);
    has_set = (k == K_SEGMENT_A) || (k == K_GAP) || (k == K_NACK_FRAGMENT);
  endfunction

  function automatic logic set_is_seq(input logic [7:0] k);
    set_is_seq = (k != K_NACK_FRAGMENT);
  endfunction

  // ---------------------------------------------------------------
  // state and set checker
  // ---------------------------------------------------------------
  psmp_state_s q;
  psmp_state_s d;
  psmp_ctx_s   ctx_init;
  logic [31:0] word_next;
  logic [15:0] len_full;
  logic [15:0] soff;
  logic        seg_last;
  logic        chk_now;
  logic        set_ok;
  logic        bad;
  logic        abort_now;

  psmp_set_check u_set_check (
    .is_seq  (set_is_seq(q.kind)),
    .base_hi (q.wa),
    .base_lo (set_is_seq(q.kind) ? q.wb : q.wa),
    .span    (word_next),
    .ok      (set_ok)
  );

  always_comb begin
    ctx_init = '0;
    ctx_init.major = SUPP_MAJOR;
    ctx_init.minor = SUPP_MINOR;
    ctx_init.vendor = VENDOR_CODE_UNSET;
  end

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.ent.valid = 1'b0;
    d.ent.first = 1'b0;
    d.ent.last = 1'b0;
    d.ent.abort = 1'b0;
    d.inv = 1'b0;
    d.done = 1'b0;
    bad = 1'b0;
    abort_now = (q.st == S_BODY) && (q.cls == C_ENTITY);
    word_next = word_shift(q.acc, in_byte.data, q.le);
    len_full = q.le ? {in_byte.data, q.len[7:0]} : {q.len[15:8], in_byte.data};
    seg_last = q.to_end ? in_byte.eop : (q.cnt == q.len - 16'h0001);
    soff = set_off(q.kind);
    chk_now = (q.st == S_BODY) && (q.cls == C_ENTITY) && has_set(q.kind)
              && (q.cnt == soff + (set_is_seq(q.kind) ? SEQ_CHK : FRAG_CHK));
    if (in_valid) begin
      if (in_byte.sop) begin
        // a new start cuts off any message still open
        d.inv = (q.st != S_IDLE) && (q.st != S_DROP);
        d.ent.abort = abort_now;
        d.ctx = ctx_init;
        d.cnt = 16'h0001;
        d.st = S_HDR;
        bad = in_byte.eop;
      end else begin
        d.cnt = q.cnt + 16'h0001;
        case (q.st)
          S_HDR: begin
            if (q.cnt == HDR_MAJ_POS) begin
              d.ctx.major = in_byte.data;
              bad = in_byte.data > SUPP_MAJOR;
            end
            if (q.cnt == HDR_MIN_POS) d.ctx.minor = in_byte.data;
            if (q.cnt == HDR_VEN_HI) d.ctx.vendor[15:8] = in_byte.data;
            if (q.cnt == HDR_VEN_LO) d.ctx.vendor[7:0] = in_byte.data;
            if (q.cnt == HDR_LAST) begin
              d.st = S_SEGH;
              d.cnt = '0;
            end else if (in_byte.eop) begin
              bad = 1'b1;
            end
          end
          S_SEGH: begin
            if (q.cnt == SEGH_KIND_POS) begin
              d.kind = in_byte.data;
              d.cls = kind_class(in_byte.data, q.ctx.vendor == KNOWN_VENDOR);
            end
            // only the byte order bit is kept, the rest never reject
            if (q.cnt == SEGH_FLAG_POS) d.le = in_byte.data[FLAG_LE_BIT];
            if (q.cnt == SEGH_LEN_A) begin
              if (q.le) d.len[7:0] = in_byte.data;
              else d.len[15:8] = in_byte.data;
            end
            if (q.cnt == SEGH_LAST) begin
              d.len = len_full;
              d.to_end = (len_full == LEN_TO_END);
              d.st = S_BODY;
              d.cnt = '0;
              d.acc = '0;
              if (q.cls != C_SKIP && len_full != LEN_TO_END && len_full < min_len(q.kind)) bad = 1'b1;
              if (in_byte.eop && len_full != LEN_TO_END) bad = 1'b1;
            end else if (in_byte.eop) begin
              bad = 1'b1;
            end
          end
          S_BODY: begin
            d.acc = word_next;
            if (in_byte.eop && !seg_last) bad = 1'b1;
            if (in_byte.eop && q.to_end && q.cls != C_SKIP && q.cnt + 16'h0001 < min_len(q.kind)) bad = 1'b1;
            if (q.cls == C_ENTITY) begin
              // context as it stands now travels with the bytes
              d.ent.valid = 1'b1;
              d.ent.first = (q.cnt == '0);
              d.ent.last = seg_last;
              d.ent.le = q.le;
              d.ent.kind = q.kind;
              d.ent.data = in_byte.data;
              if (has_set(q.kind) && q.cnt == soff + WORD_LAST) d.wa = word_next;
              if (has_set(q.kind) && q.cnt == soff + WORD2_LAST) d.wb = word_next;
              if (chk_now && !set_ok) bad = 1'b1;
            end
            if (q.cls == C_CTX) begin
              case (q.kind)
                K_TS_INFO: begin
                  if (q.cnt == TS_HI_LAST) d.ctx.ts[63:32] = word_next;
                  if (q.cnt == TS_LO_LAST) begin
                    d.ctx.ts[31:0] = word_next;
                    d.ctx.have_ts = 1'b1;
                  end
                end
                K_SRC_INFO: begin
                  if (q.cnt == HDR_MAJ_POS) d.ctx.major = in_byte.data;
                  if (q.cnt == HDR_MIN_POS) d.ctx.minor = in_byte.data;
                  if (q.cnt == HDR_VEN_HI) d.ctx.vendor[15:8] = in_byte.data;
                  if (q.cnt == HDR_VEN_LO) d.ctx.vendor[7:0] = in_byte.data;
                end
                K_DST_INFO: d.ctx.dst_seen = 1'b1;
                K_REPLY_INFO: d.ctx.reply_seen = 1'b1;
                default: d.ctx = q.ctx;
              endcase
            end
            if (seg_last) begin
              d.st = S_SEGH;
              d.cnt = '0;
            end
          end
          S_DROP: d.st = S_DROP;
          default: d.st = S_IDLE;
        endcase
      end
      if (bad) begin
        d.inv = 1'b1;
        d.ent.valid = 1'b0;
        d.ent.abort = abort_now;
        d.st = in_byte.eop ? S_IDLE : S_DROP;
      end else if (in_byte.eop) begin
        d.done = (q.st == S_HDR) || (q.st == S_SEGH) || (q.st == S_BODY) || in_byte.sop;
        d.st = S_IDLE;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      q <= ST_RESET;
    end else if (ce) begin
      q <= d;
    end
  end

  // no downstream stall: a byte is taken on every enabled cycle
  assign in_ready    = ce;
  assign ent         = q.ent;
  assign ctx         = q.ctx;
  assign msg_invalid = q.inv;
  assign msg_done    = q.done;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  seg_hdr_short_a: assert property (ce && in_valid && !in_byte.sop && in_byte.eop && q.st == S_SEGH
      && q.cnt < SEGH_LAST |=> msg_invalid && q.st == S_IDLE) else $error("short segment header not flagged");
  len_short_a: assert property (ce && in_valid && !in_byte.sop && in_byte.eop && q.st == S_BODY && !q.to_end
      && (q.cnt + 16'h0001 < q.len) |=> msg_invalid && !ent.valid) else $error("short segment not flagged");
  unknown_skip_a: assert property (ce && in_valid && !in_byte.sop && q.st == S_BODY && q.cls == C_SKIP
      |=> !ent.valid && !msg_invalid) else $error("skipped segment delivered");
  vendor_skip_a: assert property (ce && in_valid && !in_byte.sop && q.st == S_SEGH && q.cnt == SEGH_KIND_POS
      && in_byte.data >= VENDOR_KIND_MIN && q.ctx.vendor != KNOWN_VENDOR |=> q.cls == C_SKIP)
      else $error("foreign vendor segment not skipped");
  next_seg_a: assert property (ce && in_valid && !in_byte.sop && !in_byte.eop && q.st == S_BODY && !q.to_end
      && q.cnt == q.len - 16'h0001 |=> (q.st == S_SEGH && q.cnt == '0) || q.st == S_DROP)
      else $error("next segment not found by length");
  drop_hold_a: assert property (ce && in_valid && !in_byte.sop && !in_byte.eop && q.st == S_DROP
      |=> q.st == S_DROP && !ent.valid && !msg_done) else $error("invalid remainder processed");
  ctx_init_a: assert property (ce && in_valid && in_byte.sop |=> !ctx.have_ts && ctx.vendor == VENDOR_CODE_UNSET
      && ctx.major == SUPP_MAJOR) else $error("context not reset at message start");
  major_rej_a: assert property (ce && in_valid && !in_byte.sop && q.st == S_HDR && q.cnt == HDR_MAJ_POS
      && in_byte.data > SUPP_MAJOR |=> msg_invalid ##1 (!ce || !in_valid || in_byte.sop || !msg_done))
      else $error("newer major revision accepted");
  set_bad_a: assert property (ce && in_valid && !in_byte.sop && chk_now && !set_ok
      |=> msg_invalid && (ent.abort || q.st != S_BODY)) else $error("bad set accepted");
  ctx_only_a: assert property (ce && in_valid && !in_byte.sop && q.st == S_BODY && q.cls != C_CTX
      |=> $stable(ctx)) else $error("context changed by non-context segment");

endmodule

// *** psmp_parser_tb.sv ***
// self-checking testbench of the message segment parser
`timescale 1ns/100ps
module psmp_parser_tb;
  import psmp_pkg::*;
  logic       clock = 1'b0;
  logic       reset_n = 1'b0;
  logic       ce = 1'b1;
  logic       in_valid;
  psmp_byte_s in_byte;
  logic       in_ready;
  psmp_ent_s  ent;
  psmp_ctx_s  ctx;
  logic       msg_invalid;
  logic       msg_done;
  logic       idle;
  logic [7:0] m[$];
  logic [7:0] lk, fd;
  logic       ll;
  int         errors = 0;
  int         tests_run = 0;
  int         n_ent, n_ab, n_dn, n_iv, n_ls;

  localparam logic [15:0] KNOWN_VENDOR_TB = 16'h5a5a;
  localparam logic [7:0]  SUPP_MAJOR_TB   = 8'h02;

  always #2.5 clock = ~clock;

  psmp_parser uut (.clock(clock), .reset_n(reset_n), .ce(ce), .in_valid(in_valid),
    .in_byte(in_byte), .in_ready(in_ready), .ent(ent), .ctx(ctx),
    .msg_invalid(msg_invalid), .msg_done(msg_done));
  psmp_xport xp (.clock(clock), .reset_n(reset_n), .in_ready(in_ready),
    .in_valid(in_valid), .in_byte(in_byte), .idle(idle));

  always @(posedge clock) begin
    if (ent.valid === 1'b1) begin
      n_ent++;
      lk = ent.kind;
      ll = ent.le;
      if (ent.first === 1'b1) fd = ent.data;
      if (ent.last === 1'b1) n_ls++;
    end
    if (ent.abort === 1'b1) n_ab++;
    if (msg_done === 1'b1) n_dn++;
    if (msg_invalid === 1'b1) n_iv++;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic finish_test();
    if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("FAIL %s exp %0h got %0h", nm, e, g);
    end
  endtask

  task automatic b(input logic [7:0] v);
    m.push_back(v);
  endtask

  task automatic w4(input logic [31:0] v, input logic le);
    for (int i = 0; i < 4; i++) b(le ? v[8*i+:8] : v[8*(3-i)+:8]);
  endtask

  task automatic hdr(input logic [7:0] maj, input logic [15:0] ven);
    for (int i = 0; i < 20; i++)
      b(i == 4 ? maj : i == 5 ? 8'h03 : i == 6 ? ven[15:8] : i == 7 ? ven[7:0] : 8'h00);
  endtask

  task automatic sh(input logic [7:0] k, input logic [7:0] f, input logic [15:0] len, input int n);
    b(k);
    b(f);
    if (f[0]) begin
      b(len[7:0]);
      b(len[15:8]);
    end else begin
      b(len[15:8]);
      b(len[7:0]);
    end
    for (int i = 0; i < n; i++) b(8'h40 + i[7:0]);
  endtask

  // whole message to the transport, then wait for its verdict
  task automatic send();
    int k;
    n_ent = 0;
    n_ab = 0;
    n_dn = 0;
    n_iv = 0;
    n_ls = 0;
    for (int i = 0; i < m.size(); i++) xp.push({i == 0, i == m.size() - 1, m[i]});
    m.delete();
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (!(idle === 1'b1 && (n_dn + n_iv) != 0) && k < 400);
    if (k >= 400) begin
      errors++;
      $display("FAIL wait exp 1 got 0");
      finish_test();
    end
    repeat (3) @(posedge clock);
  endtask

  task automatic verdict(input string nm, input int e, input int d, input int v);
    chk({nm, " ent"}, e, n_ent);
    chk({nm, " done"}, d, n_dn);
    chk({nm, " inv"}, v, n_iv);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_clean();
    hdr(8'h02, 16'h0001);
    sh(K_DATA, 8'h00, 16'h0002, 2);
    send();
    verdict("clean", 2, 1, 0);
    chk("first data", 8'h40, fd);
    chk("last", 1, n_ls);
    chk("le clear", 1'b0, ll);
    chk("major", 8'h02, ctx.major);
    chk("minor", 8'h03, ctx.minor);
    chk("vendor", 16'h0001, ctx.vendor);
    hdr(8'h02, 16'h0001);
    sh(K_DATA, 8'h01, LEN_TO_END, 3);
    send();
    verdict("to end", 3, 1, 0);
    chk("to end last", 1, n_ls);
    chk("le set", 1'b1, ll);
  endtask

  task automatic t_skip();
    hdr(8'h02, 16'h0001);
    sh(8'h20, 8'hfe, 16'h0003, 3);
    sh(VENDOR_KIND_MIN, 8'h00, 16'h0002, 2);
    sh(K_DATA, 8'hfe, 16'h0001, 1);
    send();
    verdict("skip", 1, 1, 0);
    chk("kind", K_DATA, lk);
    hdr(8'h02, KNOWN_VENDOR_TB);
    sh(VENDOR_KIND_MIN, 8'h00, 16'h0002, 2);
    send();
    verdict("vendor", 2, 1, 0);
  endtask

  task automatic t_ctx();
    hdr(8'h02, 16'h0001);
    sh(K_TS_INFO, 8'h01, 16'h000c, 0);
    w4(32'h1234_5678, 1'b1);
    w4(32'h90ab_cdef, 1'b1);
    w4(32'h0000_0000, 1'b1);
    sh(K_DST_INFO, 8'h00, MIN_DST_INFO, 12);
    sh(K_REPLY_INFO, 8'h00, 16'h0004, 4);
    sh(K_DATA, 8'h00, 16'h0001, 1);
    send();
    verdict("ts", 1, 1, 0);
    chk("ts", 64'h1234_5678_90ab_cdef, ctx.ts);
    chk("have ts", 1'b1, ctx.have_ts);
    chk("dst seen", 1'b1, ctx.dst_seen);
    chk("reply seen", 1'b1, ctx.reply_seen);
    hdr(8'h02, 16'h0001);
    sh(K_SRC_INFO, 8'h00, MIN_SRC_INFO, 0);
    hdr(8'h01, 16'h0777);
    sh(K_DATA, 8'h00, 16'h0001, 1);
    send();
    verdict("src", 1, 1, 0);
    chk("ts reset", 1'b0, ctx.have_ts);
    chk("dst reset", 1'b0, ctx.dst_seen);
    chk("src vendor", 16'h0777, ctx.vendor);
    chk("src major", 8'h01, ctx.major);
  endtask

  task automatic t_bad();
    hdr(8'h02, 16'h0001);
    b(K_DATA);
    b(8'h00);
    send();
    verdict("trunc", 0, 0, 1);
    hdr(8'h02, 16'h0001);
    sh(K_DATA, 8'h00, 16'h0004, 2);
    send();
    verdict("short", 1, 0, 1);
    chk("short abort", 1, n_ab);
    hdr(8'h02, 16'h0001);
    sh(K_TS_INFO, 8'h00, 16'h0004, 4);
    sh(K_DATA, 8'h00, 16'h0001, 1);
    send();
    verdict("bad len", 0, 0, 1);
    hdr(SUPP_MAJOR_TB + 8'h01, 16'h0001);
    sh(K_DATA, 8'h00, 16'h0001, 1);
    send();
    verdict("major", 0, 0, 1);
  endtask

  task automatic t_sets();
    logic [63:0] bs[7] = '{64'h1, 64'h0, 64'h1, 64'hffff_ffff_ffff_ffff, 64'h1, 64'h0, 64'h1};
    logic [31:0] nb[7] = '{32'h20, 32'h20, 32'h101, 32'h8, 32'h8, 32'h8, 32'h101};
    logic        ok[7] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 7; i++) begin
      hdr(8'h02, 16'h0001);
      if (i < 4) begin
        sh(K_GAP, 8'h00, MIN_GAP, 12);
        w4(32'h1, 1'b0);
        w4(bs[i][63:32], 1'b0);
        w4(bs[i][31:0], 1'b0);
      end else begin
        sh(K_NACK_FRAGMENT, 8'h00, MIN_NACK_FRAG, 16);
        w4(bs[i][31:0], 1'b0);
      end
      w4(nb[i], 1'b0);
      send();
      chk("set done", ok[i], n_dn);
      chk("set inv", !ok[i], n_iv);
    end
  endtask

  initial begin
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    t_clean();
    t_skip();
    t_ctx();
    t_bad();
    t_sets();
    finish_test();
  end
endmodule

// *** psmp_pkg.sv ***
// package: constants and types of the message segment parser
package psmp_pkg;

  // ---------------------------------------------------------------
  // message and segment header layout
  // ---------------------------------------------------------------
  localparam logic [15:0] HDR_LAST      = 16'h0013;
  localparam logic [15:0] HDR_MAJ_POS   = 16'h0004;
  localparam logic [15:0] HDR_MIN_POS   = 16'h0005;
  localparam logic [15:0] HDR_VEN_HI    = 16'h0006;
  localparam logic [15:0] HDR_VEN_LO    = 16'h0007;
  localparam logic [15:0] SEGH_KIND_POS = 16'h0000;
  localparam logic [15:0] SEGH_FLAG_POS = 16'h0001;
  localparam logic [15:0] SEGH_LEN_A    = 16'h0002;
  localparam logic [15:0] SEGH_LAST     = 16'h0003;
  localparam logic [15:0] LEN_TO_END    = 16'h0000;
  localparam int          FLAG_LE_BIT   = 0;

  // ---------------------------------------------------------------
  // segment kind codes
  // ---------------------------------------------------------------
  localparam logic [7:0] K_DATA            = 8'h01;
  localparam logic [7:0] K_DATA_FRAGMENT   = 8'h02;
  localparam logic [7:0] K_HEARTBEAT       = 8'h03;
  localparam logic [7:0] K_SEGMENT_A       = 8'h04;
  localparam logic [7:0] K_GAP             = 8'h05;
  localparam logic [7:0] K_HB_FRAGMENT     = 8'h06;
  localparam logic [7:0] K_NACK_FRAGMENT   = 8'h07;
  localparam logic [7:0] K_SRC_INFO        = 8'h08;
  localparam logic [7:0] K_REPLY_INFO      = 8'h09;
  localparam logic [7:0] K_DST_INFO        = 8'h0a;
  localparam logic [7:0] K_TS_INFO         = 8'h0b;
  localparam logic [7:0] VENDOR_KIND_MIN   = 8'h80;
  localparam logic [15:0] VENDOR_CODE_UNSET = 16'h0000;

  // ---------------------------------------------------------------
  // body layout: least lengths, set offsets, word positions
  // ---------------------------------------------------------------
  localparam logic [15:0] MIN_TS_INFO    = 16'h0008;
  localparam logic [15:0] MIN_SRC_INFO   = 16'h0014;
  localparam logic [15:0] MIN_DST_INFO   = 16'h000c;
  localparam logic [15:0] MIN_SEGMENT_A  = 16'h0014;
  localparam logic [15:0] MIN_GAP        = 16'h001c;
  localparam logic [15:0] MIN_NACK_FRAG  = 16'h0018;
  localparam logic [15:0] MIN_NONE       = 16'h0000;
  localparam logic [15:0] SET_OFF_SEG_A  = 16'h0008;
  localparam logic [15:0] SET_OFF_GAP    = 16'h0010;
  localparam logic [15:0] SET_OFF_NACKF  = 16'h0010;
  localparam logic [15:0] WORD_LAST      = 16'h0003;
  localparam logic [15:0] WORD2_LAST     = 16'h0007;
  localparam logic [15:0] SEQ_CHK        = 16'h000b;
  localparam logic [15:0] FRAG_CHK       = 16'h0007;
  localparam logic [15:0] TS_HI_LAST     = 16'h0003;
  localparam logic [15:0] TS_LO_LAST     = 16'h0007;
  localparam logic [31:0] SET_MAX_SPAN   = 32'h0000_0100;
  localparam logic signed [63:0] SEQ_MIN_BASE = 64'sh0000_0000_0000_0001;
  localparam logic [31:0] FRAG_MIN_BASE  = 32'h0000_0001;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_HDR  = 3'b001,
    S_SEGH = 3'b010,
    S_BODY = 3'b011,
    S_DROP = 3'b100
  } psmp_state_e;

  typedef enum logic [1:0] {
    C_SKIP   = 2'b00,
    C_ENTITY = 2'b01,
    C_CTX    = 2'b10
  } psmp_class_e;

  typedef struct packed {
    logic       sop;
    logic       eop;
    logic [7:0] data;
  } psmp_byte_s;

  typedef struct packed {
    logic       valid;
    logic       first;
    logic       last;
    logic       abort;
    logic       le;
    logic [7:0] kind;
    logic [7:0] data;
  } psmp_ent_s;

  typedef struct packed {
    logic [7:0]  major;
    logic [7:0]  minor;
    logic [15:0] vendor;
    logic        have_ts;
    logic [63:0] ts;
    logic        dst_seen;
    logic        reply_seen;
  } psmp_ctx_s;

  typedef struct packed {
    psmp_state_e st;
    logic [15:0] cnt;
    logic [15:0] len;
    logic        to_end;
    logic [7:0]  kind;
    logic        le;
    psmp_class_e cls;
    logic [31:0] acc;
    logic [31:0] wa;
    logic [31:0] wb;
    psmp_ctx_s   ctx;
    psmp_ent_s   ent;
    logic        inv;
    logic        done;
  } psmp_state_s;

  localparam psmp_state_s ST_RESET = '0;

endpackage

// *** psmp_set_check.sv ***
// module: validity check of a sequence or fragment bitmap set
`timescale 1ns/100ps
module psmp_set_check
  import psmp_pkg::*;
(
  // set kind
  input  wire logic        is_seq,
  // captured words
  input  wire logic [31:0] base_hi,
  input  wire logic [31:0] base_lo,
  input  wire logic [31:0] span,
  // verdict
  output logic             ok
);

  logic signed [63:0] seq_base;
  logic               base_ok;

  // sequence base is signed over the full 64-bit range
  assign seq_base = {base_hi, base_lo};
  assign base_ok  = is_seq ? (seq_base >= SEQ_MIN_BASE) : (base_lo >= FRAG_MIN_BASE);
  // a span of at most 256 bits keeps every member within base..base+255
  assign ok       = base_ok && (span <= SET_MAX_SPAN);

endmodule

// *** psmp_xport.sv ***
// model of the datagram transport feeding the parser
`timescale 1ns/100ps
module psmp_xport
  import psmp_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // byte stream
  input  wire logic in_ready,
  output logic      in_valid,
  output psmp_byte_s in_byte,
  // status
  output logic      idle
);
  psmp_byte_s q[$];

  task automatic push(input psmp_byte_s b);
    q.push_back(b);
  endtask

  // ---------------------------------------------------------------
  // one byte a cycle, held until taken
  // ---------------------------------------------------------------
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      in_valid <= 1'b0;
      in_byte  <= '0;
      idle     <= 1'b1;
    end else if (!in_valid || in_ready) begin
      if (q.size() != 0) begin
        in_valid <= 1'b1;
        in_byte  <= q.pop_front();
        idle     <= 1'b0;
      end else begin
        // released line: clear the flags and invert the data again on every idle cycle
        in_valid <= 1'b0;
        in_byte  <= {2'b00, ~in_byte.data};
        idle     <= 1'b1;
      end
    end
  end
endmodule
